// ---- hw/lvds_28bit_deserializer.sv ----
// Purpose: Receive side of a four-lane, seven-slot forwarded-clock link.
// Assumes: Link clock period of at least seven reference cycles.
// Notes:   Pins are sampled by ref_clk; slot 0 is taken in the edge-detect cycle,
//          slot k at k*T/7 after it. At T = 8 the margin depends on pin phase.
`timescale 1ns/1ps
`default_nettype none
module lvds_28bit_deserializer #(
  parameter int LOCK_CYCLES = deser_pkg::PLL_LOCK_CYCLES,
  parameter int LOSS_CYCLES = deser_pkg::CLOCK_LOSS_CYCLES,
  parameter int FIFO_DEPTH  = deser_pkg::FIFO_DEPTH
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          forwarded_clock_in,
  input  wire logic [deser_pkg::LANES-1:0]   serial_lane_in,
  input  wire logic                          power_down_n,
  input  wire logic                          downstream_ready,
  output logic      [deser_pkg::WORD_W-1:0]  parallel_word_out,
  output logic                               word_strobe_clock_out,
  output logic                               word_valid,
  output logic                               fifo_overrun
);
  localparam int CNT_W  = deser_pkg::CNT_W;
  localparam int SLOT_W = deser_pkg::SLOT_W;
  localparam int LOCK_W = deser_pkg::LOCK_W;
  localparam int DUE_W  = deser_pkg::DUE_W;
  localparam int WORD_W = deser_pkg::WORD_W;
  localparam int SLOTS  = deser_pkg::SLOTS;
  localparam int LANE3  = (deser_pkg::LANES - 1) * SLOTS;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
  localparam logic [CNT_W-1:0]  LOSS_LAST = CNT_W'(LOSS_CYCLES);
  localparam logic [SLOT_W-1:0] SLOT_END  = SLOT_W'(SLOTS);

  if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << LOCK_W) ||
      LOSS_CYCLES < 2 * SLOTS || LOSS_CYCLES >= (1 << CNT_W)) begin : bad_param
    $error("lvds_28bit_deserializer: LOCK_CYCLES or LOSS_CYCLES out of range");
  end

  typedef struct packed {
    deser_pkg::lane_sample_s s1;
    deser_pkg::lane_sample_s s2;
    logic                    pd1;
    logic                    pd2;
    logic                    clk_prev;
    deser_pkg::link_state_e  state;
    logic [CNT_W-1:0]        phase;
    logic [CNT_W-1:0]        period;
    logic [CNT_W-1:0]        idle_cnt;
    logic [LOCK_W-1:0]       lock_cnt;
    logic [SLOT_W-1:0]       slot;
    logic [WORD_W-1:0]       shift;
    logic                    push;
    logic [WORD_W-1:0]       push_word;
    logic [WORD_W-1:0]       word;
    logic                    strobe;
    logic                    valid;
    logic                    overrun;
  } rx_state_s;

  rx_state_s         r_reg;
  rx_state_s         r_next;
  logic              rise;
  logic              fire;
  logic              pop;
  logic [CNT_W-1:0]  ph;
  logic [SLOT_W-1:0] sl;
  logic [WORD_W-1:0] sampled;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;

  // Slot k is due once phase*7 reaches k*period
  function automatic logic slot_due(input logic [CNT_W-1:0]  ph,
                                    input logic [SLOT_W-1:0] sl,
                                    input logic [CNT_W-1:0]  per);
    logic [DUE_W-1:0] lhs;
    logic [DUE_W-1:0] rhs;
    lhs = DUE_W'(ph) * DUE_W'(SLOTS);
    rhs = DUE_W'(sl) * DUE_W'(per);
    return lhs >= rhs;
  endfunction

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .reset     (reset),
    .in_valid  (r_reg.push),
    .in_ready  (fifo_in_ready),
    .in_data   (r_reg.push_word),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    r_next  = r_reg;
    sampled = r_reg.shift;
    fire    = 1'b0;
    pop     = 1'b0;
    // Two-stage synchronisers on the link pins and power_down_n
    r_next.s1       = '{clk: forwarded_clock_in, lane: serial_lane_in};
    r_next.s2       = r_reg.s1;
    r_next.pd1      = power_down_n;
    r_next.pd2      = r_reg.pd1;
    r_next.clk_prev = r_reg.s2.clk;
    rise            = r_reg.s2.clk && !r_reg.clk_prev;
    // Lanes and clock share the synchroniser, so slot 0 is due in the detect cycle
    ph              = rise ? '0 : r_reg.phase;
    sl              = rise ? '0 : r_reg.slot;

    // Idle lanes are biased high, so they sample as ones
    if (sl < SLOT_END && slot_due(ph, sl, r_reg.period)) begin
      fire = 1'b1;
      for (int l = 0; l < deser_pkg::LANES; l++) begin
        sampled[l * SLOTS + int'(sl)] = r_reg.s2.lane[l];
      end
    end
    r_next.shift = sampled;
    r_next.slot  = fire ? sl + SLOT_W'(1) : sl;

    r_next.push = 1'b0;
    if (rise) begin
      r_next.phase     = CNT_W'(1);
      r_next.period    = r_reg.phase;
      r_next.idle_cnt  = '0;
      r_next.push      = (r_reg.state != deser_pkg::LINK_IDLE);
      // Completed word, before this cycle's slot 0 sample lands
      r_next.push_word = r_reg.shift;
      r_next.strobe    = (r_reg.state != deser_pkg::LINK_IDLE);
    end else begin
      if (r_reg.phase != '1) begin
        r_next.phase = r_reg.phase + CNT_W'(1);
      end
      if (r_reg.idle_cnt != LOSS_LAST) begin
        r_next.idle_cnt = r_reg.idle_cnt + CNT_W'(1);
      end
      // Half-period high time
      if (r_reg.phase >= (r_reg.period >> 1)) begin
        r_next.strobe = 1'b0;
      end
    end

    case (r_reg.state)
      deser_pkg::LINK_IDLE: begin
        if (rise) begin
          r_next.state    = deser_pkg::LINK_LOCKING;
          r_next.lock_cnt = '0;
        end
      end
      deser_pkg::LINK_LOCKING: begin
        if (r_reg.lock_cnt == LOCK_LAST) begin
          r_next.state = deser_pkg::LINK_RUN;
        end else begin
          r_next.lock_cnt = r_reg.lock_cnt + LOCK_W'(1);
        end
      end
      deser_pkg::LINK_RUN: begin
      end
      default: begin
        r_next.state = deser_pkg::LINK_IDLE;
      end
    endcase
    if (!rise && r_reg.idle_cnt == LOSS_LAST) begin
      r_next.state = deser_pkg::LINK_IDLE;
    end
    if (r_next.state == deser_pkg::LINK_IDLE) begin
      r_next.strobe = 1'b0;
    end

    // New word launched on the strobe's falling edge, captured on its next rise
    pop = r_reg.strobe && !r_next.strobe && fifo_out_valid && downstream_ready;
    if (pop) begin
      r_next.word = fifo_out_data;
    end
    if (r_reg.push && !fifo_in_ready) begin
      r_next.overrun = 1'b1;
    end
    r_next.valid = (r_next.state == deser_pkg::LINK_RUN) && r_reg.pd2;

    if (!r_reg.pd2) begin
      r_next.word    = '0;
      r_next.strobe  = 1'b0;
      r_next.valid   = 1'b0;
      r_next.overrun = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign parallel_word_out     = r_reg.word;
  assign word_strobe_clock_out = r_reg.strobe;
  assign word_valid            = r_reg.valid;
  assign fifo_overrun          = r_reg.overrun;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  pd_forces_low_a: assert property (!r_reg.pd2 |=> parallel_word_out == '0 &&
                                    !word_strobe_clock_out && !word_valid)
    else $error("outputs not low during power-down");
  idle_strobe_low_a: assert property (r_reg.state == deser_pkg::LINK_IDLE |->
                                      !word_strobe_clock_out)
    else $error("output clock active while link idle");
  idle_word_hold_a: assert property (r_reg.state == deser_pkg::LINK_IDLE &&
                                     $past(r_reg.state) == deser_pkg::LINK_IDLE &&
                                     r_reg.pd2 |=> $stable(parallel_word_out))
    else $error("word changed while link idle");
  strobe_data_stable_a: assert property ($rose(word_strobe_clock_out) &&
                                         $past(r_reg.pd2) |-> $stable(parallel_word_out))
    else $error("data changed at output clock rise");
  word_per_edge_a: assert property (rise && r_reg.state != deser_pkg::LINK_IDLE |=>
                                    r_reg.push ##1 !r_reg.push)
    else $error("no word pushed for link clock edge");
  first_slot_a: assert property (rise |-> fire ##1 r_reg.slot == SLOT_W'(1))
    else $error("slot 0 not sampled first after edge");
  lock_wait_a: assert property (r_reg.state == deser_pkg::LINK_LOCKING &&
                                r_reg.lock_cnt < LOCK_LAST |=> !word_valid)
    else $error("valid before lock time elapsed");
  lane_high_a: assert property (fire && (&r_reg.s2.lane) |=>
                                r_reg.shift[$past(sl)] &&
                                r_reg.shift[LANE3 + int'($past(sl))])
    else $error("high lane not sampled as one");

  run_reached_c: cover property (r_reg.state == deser_pkg::LINK_RUN && word_valid);
  word_popped_c: cover property (pop ##[1:8] $rose(word_strobe_clock_out));
  overrun_seen_c: cover property ($rose(fifo_overrun));
  clock_lost_c: cover property (r_reg.state == deser_pkg::LINK_RUN ##1
                                r_reg.state == deser_pkg::LINK_IDLE);

endmodule // lvds_28bit_deserializer
`default_nettype wire

// ---- hw/deser_pkg.sv ----
// Purpose: Shared constants and carriers for the 28-bit link receiver.
// Assumes: Reference clock of 40 MHz; link clock well below it.
// Notes:   Bit mapping is parallel index = lane * 7 + slot.
//
// Behaviour
// - Rebuild one 28-bit word from four lanes every link clock period.
// - Sample each lane at seven evenly spaced slots, slot 0 first.
// - Output data is stable around the rising edge of the output clock.
// - Power-down low forces every parallel output low.
// - Idle lanes read high, so a toggling clock yields all-ones words.
// - With clock and lanes idle, data outputs hold the last word.
// - With the link clock idle, the output clock stays low.
// - Receiver latency is two link clock periods plus fixed delay.
// - Output is flagged invalid until the lock time has elapsed.
package deser_pkg;

  localparam int LANES  = 4;
  localparam int SLOTS  = 7;
  localparam int WORD_W = LANES * SLOTS;
  localparam int FIFO_DEPTH = 16;

  // Widths for the phase, period, clock-loss, slot and lock counters, and the slot-due product
  localparam int CNT_W  = 8;
  localparam int SLOT_W = 3;
  localparam int LOCK_W = 20;
  localparam int DUE_W  = CNT_W + SLOT_W;

  // Timing: lock time in its own unit, converted to reference cycles
  localparam int REF_CLK_KHZ      = 40000;
  localparam int PLL_LOCK_TIME_MS = 10;
  localparam int PLL_LOCK_CYCLES  = PLL_LOCK_TIME_MS * REF_CLK_KHZ;

  // Reference cycles without a link clock edge before the link counts as idle
  localparam int CLOCK_LOSS_CYCLES = 64;

  typedef enum logic [1:0] {
    LINK_IDLE    = 2'b00,
    LINK_LOCKING = 2'b01,
    LINK_RUN     = 2'b10
  } link_state_e;

  // One sample of the link pins
  typedef struct packed {
    logic             clk;
    logic [LANES-1:0] lane;
  } lane_sample_s;

endpackage

// ---- hw/word_fifo.sv ----
// Purpose: Word FIFO between the link sampler and the output stage.
// Assumes: Single clock; DEPTH a power of two.
// Notes:   Write when full and read when empty are ignored.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = deser_pkg::WORD_W,
  parameter int DEPTH = deser_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_param
    $error("word_fifo: DEPTH must be a power of two and at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_state_s;

  fifo_state_s r_reg;
  fifo_state_s r_next;
  logic        full;
  logic        empty;

  always_comb begin
    r_next    = r_reg;
    full      = (r_reg.wr[AW] != r_reg.rd[AW]) && (r_reg.wr[AW-1:0] == r_reg.rd[AW-1:0]);
    empty     = (r_reg.wr == r_reg.rd);
    in_ready  = !full;
    out_valid = !empty;
    out_data  = r_reg.mem[r_reg.rd[AW-1:0]];
    if (in_valid && !full) begin
      r_next.mem[r_reg.wr[AW-1:0]] = in_data;
      r_next.wr = r_reg.wr + (AW+1)'(1);
    end
    if (out_ready && !empty) begin
      r_next.rd = r_reg.rd + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  no_overfill_a: assert property (full && in_valid && !(out_ready && !empty) |=> full)
    else $error("fifo lost full state");
  count_step_a: assert property (in_valid && !full && !out_ready |=> !empty)
    else $error("fifo empty after write");

endmodule // word_fifo
`default_nettype wire

// ---- tb/link_tx_model.sv ----
// Purpose: Transmitter side of the link: forwarded clock and four lanes.
// Assumes: Link period 200 ns, seven slots per period, clock high slots 0..3.
// Notes:   Stopped link parks the clock low and lets lanes float high.
//          Frames start 3.5 ns before a ref_clk rise, where the slot grid has margin.
`timescale 1ns/1ps
`default_nettype none
module link_tx_model (
  input  wire logic                         run,
  input  wire logic                         lanes_float,
  input  wire logic [deser_pkg::WORD_W-1:0] word,
  output var  logic                         link_clk,
  output var  logic [deser_pkg::LANES-1:0]  lanes
);
  // Whole picoseconds, so seven slots add up to exactly one 200 ns period
  localparam real SLOT_NS = 28.571;
  localparam real LAST_NS = 28.574;
  localparam real IDLE_NS = 25.0;
  logic [deser_pkg::WORD_W-1:0] frame;
  initial begin
    link_clk = 1'b0;
    lanes = 4'hF;
    #9;
    forever begin
      if (run) begin
        frame = word;
        for (int k = 0; k < deser_pkg::SLOTS; k++) begin
          link_clk = (k < 4);
          for (int l = 0; l < deser_pkg::LANES; l++) begin
            lanes[l] = lanes_float | frame[l * deser_pkg::SLOTS + k];
          end
          #(k == deser_pkg::SLOTS - 1 ? LAST_NS : SLOT_NS);
        end
      end else begin
        // Parked low so stopping never makes a spurious rising edge
        link_clk = 1'b0;
        lanes = 4'hF;
        // Idle steps of one ref period keep the restart phase unchanged
        #(IDLE_NS);
      end
    end
  end
endmodule // link_tx_model
`default_nettype wire

// ---- tb/test_lvds_28bit_deserializer.sv ----
// Purpose: Self-checking bench for the link receiver.
// Assumes: Shortened lock time; link driven by the transmitter model.
// Notes:   Outputs sampled on falling edges of ref_clk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module test_lvds_28bit_deserializer;
  localparam int LOCK = 20;
  localparam int LOSS = 64;
  logic        ref_clk, reset, power_down_n, downstream_ready, run, lanes_float;
  logic [27:0] word, parallel_word_out;
  logic [3:0]  lanes;
  logic        link_clk, word_strobe_clock_out, word_valid, fifo_overrun;
  int          errors, comparisons;

  link_tx_model tx (.run(run), .lanes_float(lanes_float), .word(word),
                    .link_clk(link_clk), .lanes(lanes));
  lvds_28bit_deserializer #(.LOCK_CYCLES(LOCK), .LOSS_CYCLES(LOSS), .FIFO_DEPTH(16)) dut (
    .ref_clk(ref_clk), .reset(reset), .forwarded_clock_in(link_clk),
    .serial_lane_in(lanes), .power_down_n(power_down_n),
    .downstream_ready(downstream_ready), .parallel_word_out(parallel_word_out),
    .word_strobe_clock_out(word_strobe_clock_out), .word_valid(word_valid),
    .fifo_overrun(fifo_overrun));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Sel 0 waits for a link clock rise, sel 1 for an output strobe rise
  task automatic wait_rise(input bit sel);
    logic prev, cur;
    prev = sel ? word_strobe_clock_out : link_clk;
    for (int n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      cur = sel ? word_strobe_clock_out : link_clk;
      if (!prev && cur) return;
      prev = cur;
    end
    errors++;
    $display("timeout at %0t", $time);
    summarize();
  endtask

  task automatic t_lock;
    int n;
    run = 1'b1;
    wait_rise(0);
    for (n = 0; n < 200 && word_valid !== 1'b1; n++) @(negedge ref_clk);
    `CHK(n >= LOCK, 1'b1)
    `CHK(n <= LOCK + 8, 1'b1)
    $display("test lock done");
  endtask

  task automatic t_patterns;
    logic [27:0] pat [6] = '{28'h0000001, 28'h0000040, 28'h0000080,
                             28'h8000000, 28'h5A3C96F, 28'hA5C3690};
    for (int i = 0; i < 6; i++) begin
      word = pat[i];
      repeat (4) wait_rise(0);
      wait_rise(1);
      `CHK(parallel_word_out, pat[i])
    end
    lanes_float = 1'b1;
    repeat (4) wait_rise(0);
    wait_rise(1);
    `CHK(parallel_word_out, 28'hFFFFFFF)
    lanes_float = 1'b0;
    $display("test patterns done");
  endtask

  task automatic t_latency;
    word = 28'h1111111;
    repeat (4) wait_rise(0);
    word = 28'h2222222;
    repeat (2) wait_rise(0);
    wait_rise(1);
    `CHK(parallel_word_out, 28'h1111111)
    wait_rise(0);
    wait_rise(1);
    `CHK(parallel_word_out, 28'h2222222)
    $display("test latency done");
  endtask

  task automatic t_overrun;
    downstream_ready = 1'b0;
    word = 28'h0C0FFEE;
    repeat (20) wait_rise(0);
    `CHK(parallel_word_out, 28'h2222222)
    `CHK(fifo_overrun, 1'b1)
    downstream_ready = 1'b1;
    repeat (20) wait_rise(0);
    wait_rise(1);
    `CHK(parallel_word_out, 28'h0C0FFEE)
    `CHK(fifo_overrun, 1'b1)
    $display("test overrun done");
  endtask

  task automatic t_loss;
    run = 1'b0;
    repeat (LOSS + 10) @(negedge ref_clk);
    for (int i = 0; i < 16; i++) begin
      @(negedge ref_clk);
      `CHK(word_strobe_clock_out, 1'b0)
      `CHK(parallel_word_out, 28'h0C0FFEE)
    end
    `CHK(word_valid, 1'b0)
    $display("test clock loss done");
  endtask

  task automatic t_power_down;
    run = 1'b1;
    repeat (4) wait_rise(0);
    power_down_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    for (int i = 0; i < 24; i++) begin
      @(negedge ref_clk);
      `CHK({parallel_word_out, word_strobe_clock_out, word_valid}, 30'h0)
    end
    `CHK(fifo_overrun, 1'b0)
    $display("test power down done");
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    reset = 1'b1;
    power_down_n = 1'b1;
    downstream_ready = 1'b1;
    run = 1'b0;
    lanes_float = 1'b0;
    word = 28'h0;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    t_lock();
    t_patterns();
    t_latency();
    t_overrun();
    t_loss();
    t_power_down();
    summarize();
  end
endmodule // test_lvds_28bit_deserializer
`default_nettype wire
